// ---- core/qpc_pkg.sv ----
// Constants, register map and state type of the position counter control
// Behaviour
// - Mode 00: index event clears position count
// - Mode 01: count wraps at configured maximum
// - Mode 10: only first index event clears count
// - Mode 11: unit time event clears count
// - Strobe init 10 loads init on rising
// - Strobe init 11: rise clockwise, fall counter-clockwise
// - Index init 10 loads init on rising
// - Index init 11 loads init on falling
// - Soft init write loads; bit stays set
// - Strobe latch 0: latch count on rising
// - Strobe polarity inverts strobe before edge detect
// - Strobe latch 1: rise clockwise, fall otherwise
// - Index latch 01 rising, 10 falling edge
// - Index latch 11 captures count and direction
// - Enable low clears flags, keeps configuration
// - Enable high lets the counter run
// - Latch mode 0: count read latches capture
// - Latch mode 1: unit timeout latches all
// - Unit timer runs only when enabled
// - Watchdog runs only when enabled
package qpc_pkg;

    // ========================================
    // Register byte addresses
    localparam logic [5:0] ADDR_CONTROL = 6'h00;
    localparam logic [5:0] ADDR_COUNT = 6'h04;
    localparam logic [5:0] ADDR_INIT = 6'h08;
    localparam logic [5:0] ADDR_MAX = 6'h0c;
    localparam logic [5:0] ADDR_STROBE_LATCH = 6'h10;
    localparam logic [5:0] ADDR_INDEX_LATCH = 6'h14;
    localparam logic [5:0] ADDR_UNIT_LATCH = 6'h18;
    localparam logic [5:0] ADDR_STATUS = 6'h1c;
    localparam logic [5:0] ADDR_DECODER = 6'h20;
    localparam logic [5:0] ADDR_CTMR_LATCH = 6'h24;
    localparam logic [5:0] ADDR_CPRD_LATCH = 6'h28;

    // ========================================
    // Control field positions
    localparam int CRM_LSB = 12;
    localparam int SEI_LSB = 10;
    localparam int IEI_LSB = 8;
    localparam int SWI_BIT = 7;
    localparam int SEL_BIT = 6;
    localparam int IEL_LSB = 4;
    localparam int COUNTER_ENABLE_SOFTRESET_BIT = 3;
    localparam int CAPTURE_LATCH_MODE_BIT = 2;
    localparam int UTE_BIT = 1;
    localparam int WDE_BIT = 0;
    // Decoder control polarity bits
    localparam int SPOL_BIT = 5;
    localparam int IPOL_BIT = 6;
    // Status bits
    localparam int DLF_BIT = 0;
    localparam int FIRST_BIT = 1;

    // ========================================
    // Reset values
    localparam logic [15:0] CONTROL_RST = 16'h0000;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [31:0] MAX_RST = 32'h0000_0000;

    // ========================================
    // Whole module state
    typedef struct packed {
        logic [15:0] ctl;
        logic [15:0] dec;
        logic [31:0] count;
        logic [31:0] init;
        logic [31:0] max;
        logic [31:0] slat;
        logic [31:0] ilat;
        logic [31:0] ulat;
        logic [15:0] ctlat;
        logic [15:0] cplat;
        logic dir_latch;
        logic first_seen;
        logic [1:0] s_sync;
        logic [1:0] i_sync;
        logic s_prev;
        logic i_prev;
        logic ack;
        logic [31:0] rdata;
    } state_t;

endpackage : qpc_pkg

// ---- core/quadrature_position_counter_control.sv ----
// Position counter control with Avalon-MM register slave
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module quadrature_position_counter_control (
    input wire logic clock_in, // 100 MHz system clock
    input wire logic sys_rst_in, // Synchronous reset, active high
    input wire logic clk_en_in, // Freezes all state when low
    input wire logic [5:0] avs_address_in, // Byte address
    input wire logic avs_read_in, // Read request
    input wire logic avs_write_in, // Write request
    input wire logic [31:0] avs_writedata_in, // Write data
    input wire logic [3:0] avs_byteenable_in, // Byte lanes
    output logic [31:0] avs_readdata_out, // Read data
    output logic avs_waitrequest_out, // Stall request
    input wire logic strobe_input_in, // Strobe pin, asynchronous
    input wire logic index_input_in, // Index pin, asynchronous
    input wire logic direction_in, // 1 = clockwise, from decoder
    input wire logic count_pulse_in, // One-cycle count step
    input wire logic unit_time_event_in, // One-cycle unit timeout
    input wire logic [15:0] capture_timer_in, // Live capture timer
    input wire logic [15:0] capture_period_in, // Live capture period
    output logic [31:0] position_count_out, // Current count
    output logic unit_timer_run_out, // Unit timer enable
    output logic watchdog_run_out // Watchdog enable
);

    // ========================================
    // State and decoded helpers
    qpc_pkg::state_t q;
    qpc_pkg::state_t n;
    localparam qpc_pkg::state_t RESET_STATE = '{
        ctl: qpc_pkg::CONTROL_RST,
        dec: qpc_pkg::CONTROL_RST,
        count: qpc_pkg::WORD_RST,
        init: qpc_pkg::WORD_RST,
        max: qpc_pkg::MAX_RST,
        slat: qpc_pkg::WORD_RST,
        ilat: qpc_pkg::WORD_RST,
        ulat: qpc_pkg::WORD_RST,
        ctlat: qpc_pkg::CONTROL_RST,
        cplat: qpc_pkg::CONTROL_RST,
        dir_latch: 1'b0,
        first_seen: 1'b0,
        s_sync: 2'b00,
        i_sync: 2'b00,
        s_prev: 1'b0,
        i_prev: 1'b0,
        ack: 1'b0,
        rdata: qpc_pkg::WORD_RST
    };

    logic [31:0] be_mask;
    logic req;
    logic wr_fire;
    logic rd_fire;
    logic s_eff;
    logic i_eff;

    // Byte-enable mask, one lane per byte
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb = gb + 1) begin : g_lane
            assign be_mask[gb*8 +: 8] = {8{avs_byteenable_in[gb]}};
        end
    endgenerate

    // One wait cycle per access; request completes when ack is up
    assign req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = req & ~(q.ack & clk_en_in);
    assign wr_fire = avs_write_in & q.ack;
    assign rd_fire = avs_read_in & q.ack;

    // Polarity applied after the second synchroniser stage
    assign s_eff = q.s_sync[1] ^ q.dec[qpc_pkg::SPOL_BIT];
    assign i_eff = q.i_sync[1] ^ q.dec[qpc_pkg::IPOL_BIT];

    // Outputs straight from state
    assign avs_readdata_out = q.rdata;
    assign position_count_out = q.count;
    assign unit_timer_run_out = q.ctl[qpc_pkg::UTE_BIT] &
        q.ctl[qpc_pkg::COUNTER_ENABLE_SOFTRESET_BIT];
    assign watchdog_run_out = q.ctl[qpc_pkg::WDE_BIT] &
        q.ctl[qpc_pkg::COUNTER_ENABLE_SOFTRESET_BIT];

    // ========================================
    // Next-state logic
    always_comb begin
        logic en;
        logic cw;
        logic s_rise;
        logic s_fall;
        logic i_rise;
        logic i_fall;
        logic unit_evt;
        logic [1:0] crm;
        logic [1:0] strobe_init_select;
        logic [1:0] index_init_select;
        logic [1:0] index_latch_select;
        logic do_init;
        logic [31:0] wval;
        en = 1'b0;
        cw = 1'b0;
        s_rise = 1'b0;
        s_fall = 1'b0;
        i_rise = 1'b0;
        i_fall = 1'b0;
        unit_evt = 1'b0;
        crm = 2'b00;
        strobe_init_select = 2'b00;
        index_init_select = 2'b00;
        index_latch_select = 2'b00;
        do_init = 1'b0;
        wval = 32'h0000_0000;
        n = q;

        // Bus handshake: ack rises after one wait cycle
        n.ack = req & ~q.ack;

        // Two-stage synchronisers and edge history
        n.s_sync = {q.s_sync[0], strobe_input_in};
        n.i_sync = {q.i_sync[0], index_input_in};
        n.s_prev = s_eff;
        n.i_prev = i_eff;

        en = q.ctl[qpc_pkg::COUNTER_ENABLE_SOFTRESET_BIT];
        cw = direction_in;
        s_rise = s_eff & ~q.s_prev;
        s_fall = ~s_eff & q.s_prev;
        i_rise = i_eff & ~q.i_prev;
        i_fall = ~i_eff & q.i_prev;
        unit_evt = unit_time_event_in & q.ctl[qpc_pkg::UTE_BIT];
        crm = q.ctl[qpc_pkg::CRM_LSB +: 2];
        strobe_init_select = q.ctl[qpc_pkg::SEI_LSB +: 2];
        index_init_select = q.ctl[qpc_pkg::IEI_LSB +: 2];
        index_latch_select = q.ctl[qpc_pkg::IEL_LSB +: 2];

        // Counting with maximum-position wrap
        if (count_pulse_in) begin
            if (cw) begin
                if (crm == 2'b01 && q.count == q.max) begin
                    n.count = 32'h0000_0000;
                end else begin
                    n.count = q.count + 32'h0000_0001;
                end
            end else begin
                if (crm == 2'b01 && q.count == 32'h0000_0000) begin
                    n.count = q.max;
                end else begin
                    n.count = q.count - 32'h0000_0001;
                end
            end
        end

        // Reset modes
        if (crm == 2'b00 && i_rise) begin
            n.count = 32'h0000_0000;
        end else if (crm == 2'b10 && i_rise && !q.first_seen) begin
            n.count = 32'h0000_0000;
        end else if (crm == 2'b11 && unit_evt) begin
            n.count = 32'h0000_0000;
        end
        if (i_rise) begin
            n.first_seen = 1'b1;
        end

        // Initialisation sources
        if (strobe_init_select == 2'b10 && s_rise) begin
            do_init = 1'b1;
        end else if (strobe_init_select == 2'b11 && (cw ? s_rise : s_fall)) begin
            do_init = 1'b1;
        end
        if (index_init_select == 2'b10 && i_rise) begin
            do_init = 1'b1;
        end else if (index_init_select == 2'b11 && i_fall) begin
            do_init = 1'b1;
        end
        if (wr_fire && avs_address_in == qpc_pkg::ADDR_CONTROL &&
            avs_byteenable_in[0] && avs_writedata_in[qpc_pkg::SWI_BIT]) begin
            do_init = 1'b1;
        end
        if (do_init) begin
            n.count = q.init;
        end

        // Strobe latch
        if (!q.ctl[qpc_pkg::SEL_BIT] && s_rise) begin
            n.slat = q.count;
        end else if (q.ctl[qpc_pkg::SEL_BIT] && (cw ? s_rise : s_fall)) begin
            n.slat = q.count;
        end

        // Index latch and direction latch
        if (index_latch_select == 2'b01 && i_rise) begin
            n.ilat = q.count;
        end else if (index_latch_select == 2'b10 && i_fall) begin
            n.ilat = q.count;
        end else if (index_latch_select == 2'b11 && i_rise) begin
            n.ilat = q.count;
            n.dir_latch = cw;
        end

        // Capture latch modes
        if (!q.ctl[qpc_pkg::CAPTURE_LATCH_MODE_BIT] && rd_fire &&
            avs_address_in == qpc_pkg::ADDR_COUNT) begin
            n.ctlat = capture_timer_in;
            n.cplat = capture_period_in;
        end else if (q.ctl[qpc_pkg::CAPTURE_LATCH_MODE_BIT] && unit_evt) begin
            n.ulat = q.count;
            n.ctlat = capture_timer_in;
            n.cplat = capture_period_in;
        end

        // Register writes, byte lanes honoured
        if (wr_fire) begin
            if (avs_address_in == qpc_pkg::ADDR_CONTROL) begin
                wval = ({16'h0000, q.ctl} & ~be_mask) |
                    (avs_writedata_in & be_mask);
                n.ctl = wval[15:0];
            end else if (avs_address_in == qpc_pkg::ADDR_COUNT) begin
                n.count = (q.count & ~be_mask) | (avs_writedata_in & be_mask);
            end else if (avs_address_in == qpc_pkg::ADDR_INIT) begin
                n.init = (q.init & ~be_mask) | (avs_writedata_in & be_mask);
            end else if (avs_address_in == qpc_pkg::ADDR_MAX) begin
                n.max = (q.max & ~be_mask) | (avs_writedata_in & be_mask);
            end else if (avs_address_in == qpc_pkg::ADDR_DECODER) begin
                wval = ({16'h0000, q.dec} & ~be_mask) |
                    (avs_writedata_in & be_mask);
                n.dec = wval[15:0];
            end
        end

        // Soft reset holds flags and read-only registers cleared
        if (!en) begin
            n.count = qpc_pkg::WORD_RST;
            n.slat = qpc_pkg::WORD_RST;
            n.ilat = qpc_pkg::WORD_RST;
            n.ulat = qpc_pkg::WORD_RST;
            n.ctlat = qpc_pkg::CONTROL_RST;
            n.cplat = qpc_pkg::CONTROL_RST;
            n.dir_latch = 1'b0;
            n.first_seen = 1'b0;
        end
        // Enabled: counting logic above takes effect

        // Read data prepared during the wait cycle
        if (avs_read_in && !q.ack) begin
            if (avs_address_in == qpc_pkg::ADDR_CONTROL) begin
                n.rdata = {16'h0000, q.ctl};
            end else if (avs_address_in == qpc_pkg::ADDR_COUNT) begin
                n.rdata = q.count;
            end else if (avs_address_in == qpc_pkg::ADDR_INIT) begin
                n.rdata = q.init;
            end else if (avs_address_in == qpc_pkg::ADDR_MAX) begin
                n.rdata = q.max;
            end else if (avs_address_in == qpc_pkg::ADDR_STROBE_LATCH) begin
                n.rdata = q.slat;
            end else if (avs_address_in == qpc_pkg::ADDR_INDEX_LATCH) begin
                n.rdata = q.ilat;
            end else if (avs_address_in == qpc_pkg::ADDR_UNIT_LATCH) begin
                n.rdata = q.ulat;
            end else if (avs_address_in == qpc_pkg::ADDR_STATUS) begin
                n.rdata = 32'h0000_0000;
                n.rdata[qpc_pkg::DLF_BIT] = q.dir_latch;
                n.rdata[qpc_pkg::FIRST_BIT] = q.first_seen;
            end else if (avs_address_in == qpc_pkg::ADDR_DECODER) begin
                n.rdata = {16'h0000, q.dec};
            end else if (avs_address_in == qpc_pkg::ADDR_CTMR_LATCH) begin
                n.rdata = {16'h0000, q.ctlat};
            end else if (avs_address_in == qpc_pkg::ADDR_CPRD_LATCH) begin
                n.rdata = {16'h0000, q.cplat};
            end else begin
                n.rdata = 32'h0000_0000;
            end
        end
    end

    // ========================================
    // State register
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            q <= RESET_STATE;
        end else if (clk_en_in) begin
            q <= n;
        end
    end

endmodule : quadrature_position_counter_control

// ---- sim/qpc_chk.sv ----
// Bus, run-output and count checks for the position counter control
`timescale 1ns/1ps
module qpc_chk (
    input wire logic clock_in, // System clock
    input wire logic sys_rst_in, // Sync reset
    input wire logic clk_en_in, // Clock enable
    input wire logic [5:0] avs_address_in, // Address
    input wire logic avs_read_in, // Read
    input wire logic avs_write_in, // Write
    input wire logic [31:0] avs_writedata_in, // Write data
    input wire logic [3:0] avs_byteenable_in, // Lanes
    input wire logic [31:0] avs_readdata_out, // Read data
    input wire logic avs_waitrequest_out, // Stall
    input wire logic strobe_input_in, // Strobe pin
    input wire logic index_input_in, // Index pin
    input wire logic count_pulse_in, // Count step
    input wire logic unit_time_event_in, // Unit timeout
    input wire logic [31:0] position_count_out, // Count
    input wire logic unit_timer_run_out, // Unit timer run
    input wire logic watchdog_run_out // Watchdog run
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    logic [15:0] ctl_q;
    logic [2:0] quiet_q;
    logic s_q, i_q, done, busy;
    // Anything that may move the count
    assign done = avs_write_in & ~avs_waitrequest_out;
    assign busy = done | count_pulse_in | unit_time_event_in
        | (strobe_input_in ^ s_q) | (index_input_in ^ i_q);
    // Control mirror and quiet-cycle counter
    always_ff @(posedge clock_in) begin
        s_q <= strobe_input_in;
        i_q <= index_input_in;
        if (sys_rst_in) begin
            ctl_q <= 16'h0000;
            quiet_q <= 3'h0;
        end else begin
            if (done && avs_address_in == qpc_pkg::ADDR_CONTROL
                && avs_byteenable_in[1:0] == 2'h3)
                ctl_q <= avs_writedata_in[15:0];
            quiet_q <= busy ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
        end
    end
    sequence req_wait;
        (avs_read_in | avs_write_in) && avs_waitrequest_out && clk_en_in;
    endsequence
    wait_one_a: assert property (
        req_wait ##1 clk_en_in && (avs_read_in | avs_write_in)
        |-> !avs_waitrequest_out) else $error("bus answer late");
    idle_wait_a: assert property (
        !(avs_read_in | avs_write_in) |-> !avs_waitrequest_out)
        else $error("stall without request");
    clken_hold_a: assert property (
        (avs_read_in | avs_write_in) && !clk_en_in |-> avs_waitrequest_out)
        else $error("answer while frozen");
    ute_run_a: assert property (
        ctl_q == $past(ctl_q) |-> unit_timer_run_out == (ctl_q[1] & ctl_q[3]))
        else $error("unit timer run wrong");
    wde_run_a: assert property (
        ctl_q == $past(ctl_q) |-> watchdog_run_out == (ctl_q[0] & ctl_q[3]))
        else $error("watchdog run wrong");
    off_zero_a: assert property (
        !ctl_q[3] && !$past(ctl_q[3]) |-> position_count_out == 32'h0)
        else $error("count not cleared while disabled");
    count_quiet_a: assert property (
        quiet_q >= 3'h4 && !busy |=> $stable(position_count_out))
        else $error("count moved without cause");
    read_hold_a: assert property (
        !$past(avs_read_in | avs_write_in) |-> $stable(avs_readdata_out))
        else $error("read data moved while idle");
endmodule : qpc_chk
bind quadrature_position_counter_control qpc_chk qpc_chk_inst (.*);

// ---- sim/enc_model.sv ----
// Encoder strobe and index lines driven on bench request
`timescale 1ns/1ps
module enc_model (
    input wire logic clock_in, // System clock
    output logic strobe_out, // Strobe line
    output logic index_out // Index line
);
    initial begin
        strobe_out = 1'b0;
        index_out = 1'b0;
    end
    // Move one line after an edge, then hold it
    task automatic drive(input bit idx, input bit lvl, input int hold);
        @(posedge clock_in);
        if (idx)
            index_out <= lvl;
        else
            strobe_out <= lvl;
        repeat (hold) @(posedge clock_in);
    endtask : drive
endmodule : enc_model

// ---- sim/quadrature_position_counter_control_bench.sv ----
// Self-checking bench for the position counter control
`timescale 1ns/1ps
module quadrature_position_counter_control_bench;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic dir = 1'b1;
    logic step = 1'b0;
    logic tev = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [15:0] ctm = 16'h1234;
    logic [31:0] rdat, cnt, v;
    logic wt, urun, wrun, s_pin, i_pin;
    int n_fail = 0;
    int checks = 0;
    always #5 clock_in = ~clock_in;
    quadrature_position_counter_control quadrature_position_counter_control_inst (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdat), .avs_byteenable_in(4'hf),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
        .strobe_input_in(s_pin), .index_input_in(i_pin), .direction_in(dir),
        .count_pulse_in(step), .unit_time_event_in(tev),
        .capture_timer_in(ctm), .capture_period_in(16'h5678),
        .position_count_out(cnt), .unit_timer_run_out(urun),
        .watchdog_run_out(wrun));
    enc_model enc_model_inst (.clock_in(clock_in), .strobe_out(s_pin),
        .index_out(i_pin));
    // ========================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    task automatic bus(input logic w, input logic [5:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock_in);
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clock_in);
            k++;
        end while (wt && k < 60);
        v = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (k == 60) begin
            n_fail++;
            end_sim();
        end
    endtask : bus
    task automatic r(input logic [5:0] a, input logic [31:0] e,
        input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, v, e);
    endtask : r
    task automatic rc(input logic [31:0] e);
        r(qpc_pkg::ADDR_COUNT, e, "count");
    endtask : rc
    task automatic wc(input logic [31:0] d);
        bus(1'b1, qpc_pkg::ADDR_COUNT, d);
    endtask : wc
    task automatic wctl(input logic [15:0] d);
        bus(1'b1, qpc_pkg::ADDR_CONTROL, {16'h0, d});
    endtask : wctl
    task automatic pin(input bit idx, input bit lvl);
        enc_model_inst.drive(idx, lvl, idx ? 6 : 12);
    endtask : pin
    task automatic tick(input bit ev, input int n);
        repeat (n) begin
            @(posedge clock_in);
            tev <= ev;
            step <= !ev;
            @(posedge clock_in);
            tev <= 1'b0;
            step <= 1'b0;
        end
        repeat (2) @(posedge clock_in);
    endtask : tick
    // ========================================
    // Scenarios
    task automatic t_reset();
        r(qpc_pkg::ADDR_CONTROL, 32'h0, "control");
        r(6'h3c, 32'h0, "unmapped");
        @(posedge clock_in);
        clk_en_in <= 1'b0;
        fork
            rc(32'h0);
            begin
                repeat (4) @(posedge clock_in);
                clk_en_in <= 1'b1;
            end
        join
    endtask : t_reset
    task automatic t_soft();
        bus(1'b1, qpc_pkg::ADDR_MAX, 32'h5a);
        bus(1'b1, qpc_pkg::ADDR_INIT, 32'h55);
        wctl(16'h1008);
        wctl(16'h1088);
        rc(32'h55);
        r(qpc_pkg::ADDR_CONTROL, 32'h1088, "control");
        tick(1'b0, 3);
        rc(32'h58);
        tick(1'b0, 3);
        rc(32'h0);
        dir <= 1'b0;
        tick(1'b0, 1);
        rc(32'h5a);
        dir <= 1'b1;
    endtask : t_soft
    task automatic t_reset_modes();
        wctl(16'h0008);
        wc(32'h100);
        pin(1, 1);
        rc(32'h0);
        pin(1, 0);
        wctl(16'h0000);
        wctl(16'h2008);
        wc(32'h100);
        pin(1, 1);
        rc(32'h0);
        pin(1, 0);
        wc(32'h100);
        pin(1, 1);
        rc(32'h100);
        pin(1, 0);
        for (int m = 2; m < 4; m++) begin
            wctl(16'h1008 | 16'(m << 8));
            wc(32'h100);
            pin(1, 1);
            rc(m == 2 ? 32'h55 : 32'h100);
            pin(1, 0);
            rc(32'h55);
        end
    endtask : t_reset_modes
    task automatic t_strobe();
        wctl(16'h1008);
        wc(32'h21);
        pin(0, 1);
        r(qpc_pkg::ADDR_STROBE_LATCH, 32'h21, "strobe latch");
        pin(0, 0);
        bus(1'b1, qpc_pkg::ADDR_DECODER, 32'h20);
        wc(32'h33);
        pin(0, 1);
        r(qpc_pkg::ADDR_STROBE_LATCH, 32'h21, "strobe latch");
        pin(0, 0);
        r(qpc_pkg::ADDR_STROBE_LATCH, 32'h33, "strobe latch");
        bus(1'b1, qpc_pkg::ADDR_DECODER, 32'h0);
        wctl(16'h1808);
        wc(32'h40);
        pin(0, 1);
        rc(32'h55);
        pin(0, 0);
        wctl(16'h1c48);
        dir <= 1'b0;
        wc(32'h44);
        pin(0, 1);
        rc(32'h44);
        r(qpc_pkg::ADDR_STROBE_LATCH, 32'h40, "strobe latch");
        pin(0, 0);
        r(qpc_pkg::ADDR_STROBE_LATCH, 32'h44, "strobe latch");
        rc(32'h55);
        dir <= 1'b1;
    endtask : t_strobe
    task automatic t_index_latch();
        wctl(16'h1018);
        wc(32'h61);
        pin(1, 1);
        r(qpc_pkg::ADDR_INDEX_LATCH, 32'h61, "index latch");
        pin(1, 0);
        wctl(16'h1028);
        wc(32'h62);
        pin(1, 1);
        r(qpc_pkg::ADDR_INDEX_LATCH, 32'h61, "index latch");
        pin(1, 0);
        r(qpc_pkg::ADDR_INDEX_LATCH, 32'h62, "index latch");
        wctl(16'h1038);
        wc(32'h63);
        pin(1, 1);
        r(qpc_pkg::ADDR_INDEX_LATCH, 32'h63, "index latch");
        bus(1'b0, qpc_pkg::ADDR_STATUS, 32'h0);
        chk("direction latch", {31'h0, v[0]}, 32'h1);
        pin(1, 0);
    endtask : t_index_latch
    task automatic t_unit();
        wctl(16'h100e);
        @(posedge clock_in);
        chk("unit run", {31'h0, urun}, 32'h1);
        wc(32'h77);
        tick(1'b1, 1);
        r(qpc_pkg::ADDR_UNIT_LATCH, 32'h77, "unit latch");
        r(qpc_pkg::ADDR_CTMR_LATCH, 32'h1234, "timer latch");
        r(qpc_pkg::ADDR_CPRD_LATCH, 32'h5678, "period latch");
        wctl(16'h300e);
        wc(32'h7);
        tick(1'b1, 1);
        rc(32'h0);
        wctl(16'h100b);
        @(posedge clock_in);
        chk("watchdog run", {31'h0, wrun}, 32'h1);
        ctm <= 16'h4321;
        rc(32'h0);
        r(qpc_pkg::ADDR_CTMR_LATCH, 32'h4321, "timer latch");
        wc(32'h9);
        wctl(16'h0a00);
        rc(32'h0);
        r(qpc_pkg::ADDR_CONTROL, 32'h0a00, "control");
        r(qpc_pkg::ADDR_INIT, 32'h55, "init");
        chk("unit run", {31'h0, urun}, 32'h0);
    endtask : t_unit
    initial begin
        repeat (3) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_soft();
        t_reset_modes();
        t_strobe();
        t_index_latch();
        t_unit();
        end_sim();
    end
endmodule : quadrature_position_counter_control_bench
